// *** core/ldr_cfg.svh ***
// ldr_cfg.svh: numeric constants of the led dimmer setup path
// assumes: included by bare name from core files, definitions only
`ifndef LDR_CFG_SVH
`define LDR_CFG_SVH

// ****************************************
// clock and blink timing
// ****************************************
`define LDR_CLK_HZ 100000000
`define LDR_TICK_HZ 152
`define LDR_DUTY_STEPS 256
`define LDR_BASE_W 12

// ****************************************
// i2c slave address and byte layout
// ****************************************
`define LDR_ADDR_HI 4'hc
`define LDR_WR_BIT 1'h0
`define LDR_BITS_PER_BYTE 4'h8
`define LDR_AUTO_INC_BIT 4

// ****************************************
// register indices
// ****************************************
`define LDR_IDX_PRESC_A 4'h2
`define LDR_IDX_DUTY_A 4'h3
`define LDR_IDX_SEL_G0 4'h6
`define LDR_IDX_LAST 4'h9
`define LDR_IDX_FIRST 4'h0

// ****************************************
// reset values and selector codes
// ****************************************
`define LDR_PSC_RST 8'h00
`define LDR_PWM_RST 8'h80
`define LDR_LS_RST 8'h00
`define LDR_SEL_OFF 2'h0
`define LDR_SEL_ON 2'h1
`define LDR_SEL_BLINK_A 2'h2
`define LDR_SEL_BLINK_B 2'h3

`endif

// *** core/ldr_pkg.sv ***
// ldr_pkg: types shared by the led dimmer setup path
// assumes: compiled before every other core file
`default_nettype none

package ldr_pkg;
  // register pointer within the device
  typedef logic [3:0] ldr_ptr_t;
  // i2c slave receive states
  typedef enum logic [1:0] {LDR_ST_IDLE, LDR_ST_ADDR, LDR_ST_CMD, LDR_ST_DATA} ldr_st_t;
endpackage

`default_nettype wire

// *** core/ldr_byte_if.sv ***
// ldr_byte_if: bytes accepted by the i2c slave, handed to the register bank
// assumes: one clock, strobe is a single-cycle pulse
`default_nettype none

interface ldr_byte_if;
  logic byte_stb; // one accepted byte
  logic byte_is_cmd; // byte is the command byte
  logic [7:0] byte_data; // received byte
  modport src (output byte_stb, output byte_is_cmd, output byte_data);
  modport snk (input byte_stb, input byte_is_cmd, input byte_data);
endinterface

`default_nettype wire

// *** core/ldr_i2c_slave.sv ***
// ldr_i2c_slave: write-only i2c slave, start/stop, address match, ack
// assumes: scl and sda come straight from pins; rst is synchronous
`default_nettype none
`include "ldr_cfg.svh"

module ldr_i2c_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [2:0] address_select_inputs,
  output logic sda_oe,
  // accepted bytes
  ldr_byte_if.src bo
);
  import ldr_pkg::*;

  // ****************************************
  // pin synchronisers and edge history
  // ****************************************
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic [2:0] sel_s1_ff, sel_s2_ff; // address straps, two flops like any pin

  // two flops per pin, third flop only for edge detection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
      {sel_s1_ff, sel_s2_ff} <= 6'h00;
    end
    else
    begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {scl_i, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {sda_i, sda_s1_ff, sda_s2_ff};
      {sel_s1_ff, sel_s2_ff} <= {address_select_inputs, sel_s1_ff};
    end
  end

  // bus conditions
  wire scl_rise = scl_s2_ff && !scl_d_ff;
  wire scl_fall = !scl_s2_ff && scl_d_ff;
  wire start_w = scl_s2_ff && scl_d_ff && sda_d_ff && !sda_s2_ff;
  wire stop_w = scl_s2_ff && scl_d_ff && !sda_d_ff && sda_s2_ff;

  // ****************************************
  // receive state machine
  // ****************************************
  ldr_st_t st_ff; // what the next byte is
  logic [3:0] bit_cnt_ff; // bits shifted in this byte
  logic [7:0] shift_ff; // byte being received
  logic in_ack_ff; // inside the ninth clock
  logic stb_ff; // byte accepted pulse

  // own write address: fixed high part, pin-set low part
  wire addr_hit = shift_ff == {`LDR_ADDR_HI, sel_s2_ff, `LDR_WR_BIT};
  wire byte_done = bit_cnt_ff == `LDR_BITS_PER_BYTE;
  wire ack_w = (st_ff == LDR_ST_ADDR) ? addr_hit : (st_ff != LDR_ST_IDLE);

  // byte framing, ack drive and state advance
  always_ff @(posedge clk)
  begin
    stb_ff <= 1'b0;
    if (rst)
    begin
      st_ff <= LDR_ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      in_ack_ff <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (start_w)
    begin
      // start or repeated start: address byte follows
      st_ff <= LDR_ST_ADDR;
      bit_cnt_ff <= 4'h0;
      in_ack_ff <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (stop_w)
    begin
      // stop ends the write
      st_ff <= LDR_ST_IDLE;
      in_ack_ff <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (scl_rise && !byte_done && st_ff != LDR_ST_IDLE)
    begin
      // msb first
      shift_ff <= {shift_ff[6:0], sda_s2_ff};
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
    else if (scl_fall && byte_done && !in_ack_ff)
    begin
      // eighth bit done: ack slot opens
      in_ack_ff <= 1'b1;
      sda_oe <= ack_w;
      stb_ff <= ack_w && st_ff != LDR_ST_ADDR;
    end
    else if (scl_fall && in_ack_ff)
    begin
      // ack slot closes, release sda
      in_ack_ff <= 1'b0;
      sda_oe <= 1'b0;
      bit_cnt_ff <= 4'h0;
      unique case (st_ff)
        LDR_ST_IDLE: st_ff <= LDR_ST_IDLE;
        LDR_ST_ADDR: st_ff <= sda_oe ? LDR_ST_CMD : LDR_ST_IDLE;
        LDR_ST_CMD: st_ff <= LDR_ST_DATA;
        LDR_ST_DATA: st_ff <= LDR_ST_DATA;
      endcase
    end
  end

  // hand the byte over
  assign bo.byte_stb = stb_ff;
  assign bo.byte_is_cmd = st_ff == LDR_ST_CMD;
  assign bo.byte_data = shift_ff;
endmodule

`default_nettype wire

// *** core/ldr_dimmer_top.sv ***
// ldr_dimmer_top: reset, i2c setup writes, blink generators, led drivers
// assumes: pins arrive unsynchronised; one 100 MHz clock
//
// Function
// - External reset low restores all defaults.
// - Stay reset while supply below threshold.
// - Supply good releases reset into defaults.
// - Acknowledge C0h write address, selects low.
// - Command 12h sets auto-increment, prescaler a.
// - Sequential bytes fill prescalers, duties, selectors.
// - Prescaler n gives period (n+1)/152 s.
// - Selector bytes 55h/AAh/FFh/00h act accordingly.
// - Field codes: off, on, blink a, b.
// - Auto-increment pointer wraps after last register.
`default_nettype none
`include "ldr_cfg.svh"

module ldr_dimmer_top #(
  // clock cycles per duty step at prescaler zero
  parameter int unsigned BASE_DIV = `LDR_CLK_HZ / (`LDR_TICK_HZ * `LDR_DUTY_STEPS)
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // reset sources from pins
  input wire logic ext_rst_n,
  input wire logic por_ok,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] address_select_inputs,
  // open-drain led pins
  output logic [15:0] led_o,
  output logic [15:0] led_oe,
  // state visible to the system
  output logic auto_increment_flag,
  output ldr_pkg::ldr_ptr_t reg_ptr,
  output logic blink_signal_a,
  output logic blink_signal_b
);
  import ldr_pkg::*;

  // ****************************************
  // reset synchronisation and merge
  // ****************************************
  logic ext_s1_ff, ext_s2_ff; // external reset, active low
  logic por_s1_ff, por_s2_ff; // supply good
  logic rst_int_ff; // internal reset for all logic except the reset synchronisers

  // two flops per pin before anything reads them
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      {ext_s1_ff, ext_s2_ff} <= 2'h0;
      {por_s1_ff, por_s2_ff} <= 2'h0;
    end
    else
    begin
      {ext_s1_ff, ext_s2_ff} <= {ext_rst_n, ext_s1_ff};
      {por_s1_ff, por_s2_ff} <= {por_ok, por_s1_ff};
    end
  end

  // held while any of sys_rst, external or supply reset asserts; released only after all three settle
  wire rst_req = sys_rst || !ext_s2_ff || !por_s2_ff;
  always_ff @(posedge clk)
  begin
    rst_int_ff <= rst_req;
  end

  // ****************************************
  // i2c slave
  // ****************************************
  ldr_byte_if bif ();
  logic sda_oe_int; // ack drive from the slave

  // byte receiver
  ldr_i2c_slave u_slave (
    .clk(clk),
    .rst(rst_int_ff),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .address_select_inputs(address_select_inputs),
    .sda_oe(sda_oe_int),
    .bo(bif)
  );

  // sda pin drive, pulled low only during ack
  always_ff @(posedge clk)
  begin
    if (rst_int_ff)
    begin
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      sda_oe <= sda_oe_int;
      sda_o <= 1'b0;
    end
  end

  // ****************************************
  // command byte and register pointer
  // ****************************************
  wire cmd_stb = bif.byte_stb && bif.byte_is_cmd;
  wire dat_stb = bif.byte_stb && !bif.byte_is_cmd;
  wire ptr_last = reg_ptr == `LDR_IDX_LAST;
  wire [3:0] ptr_inc = ptr_last ? `LDR_IDX_FIRST : reg_ptr + 4'h1;

  // pointer load on command, advance on data when enabled
  always_ff @(posedge clk)
  begin
    if (rst_int_ff)
    begin
      reg_ptr <= `LDR_IDX_FIRST;
      auto_increment_flag <= 1'b0;
    end
    else if (cmd_stb)
    begin
      reg_ptr <= bif.byte_data[3:0];
      auto_increment_flag <= bif.byte_data[`LDR_AUTO_INC_BIT];
    end
    else if (dat_stb && auto_increment_flag)
    begin
      reg_ptr <= ptr_inc;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  logic [7:0] cfg_ff [`LDR_IDX_PRESC_A:`LDR_IDX_LAST]; // prescalers, duties, selectors
  // input registers and unused codes take the write with no effect
  wire wr_ok = dat_stb && reg_ptr >= `LDR_IDX_PRESC_A && reg_ptr <= `LDR_IDX_LAST;

  // one writable byte per index
  genvar gr;
  generate
    for (gr = `LDR_IDX_PRESC_A; gr <= `LDR_IDX_LAST; gr++)
    begin : g_reg
      // duty registers reset to half, the rest to zero
      localparam logic [7:0] RST_V = (gr == `LDR_IDX_DUTY_A || gr == `LDR_IDX_DUTY_A + 2) ?
        `LDR_PWM_RST : (gr >= `LDR_IDX_SEL_G0 ? `LDR_LS_RST : `LDR_PSC_RST);
      always_ff @(posedge clk)
      begin
        if (rst_int_ff)
          cfg_ff[gr] <= RST_V;
        else if (wr_ok && reg_ptr == 4'(gr))
          cfg_ff[gr] <= bif.byte_data;
      end
    end
  endgenerate

  // ****************************************
  // duty step time base
  // ****************************************
  logic [`LDR_BASE_W-1:0] base_cnt_ff; // cycles within one step
  wire base_tick = base_cnt_ff == `LDR_BASE_W'(BASE_DIV - 1);

  // free-running divider, one-cycle tick
  always_ff @(posedge clk)
  begin
    if (rst_int_ff || base_tick)
      base_cnt_ff <= '0;
    else
      base_cnt_ff <= base_cnt_ff + `LDR_BASE_W'(1);
  end

  // ****************************************
  // blink generators a and b
  // ****************************************
  logic [1:0] blink_on; // high while the blink output is in its on part

  genvar gb;
  generate
    for (gb = 0; gb < 2; gb++)
    begin : g_blink
      logic [7:0] pre_cnt_ff; // ticks within one step
      logic [7:0] duty_cnt_ff; // step within the period
      logic on_ff; // on while step below duty
      wire [7:0] psc = cfg_ff[`LDR_IDX_PRESC_A + 4'(2 * gb)];
      wire [7:0] pwm = cfg_ff[`LDR_IDX_DUTY_A + 4'(2 * gb)];
      wire pwm_wr = wr_ok && reg_ptr == `LDR_IDX_DUTY_A + 4'(2 * gb);
      // step advances after psc+1 base ticks: period (psc+1)/152 s
      wire step = base_tick && pre_cnt_ff == psc;

      // counters restart after a duty write
      always_ff @(posedge clk)
      begin
        if (rst_int_ff || pwm_wr)
        begin
          pre_cnt_ff <= 8'h00;
          duty_cnt_ff <= 8'h00;
          on_ff <= 1'b0;
        end
        else
        begin
          if (step)
            pre_cnt_ff <= 8'h00;
          else if (base_tick)
            pre_cnt_ff <= pre_cnt_ff + 8'h01;
          if (step)
            duty_cnt_ff <= duty_cnt_ff + 8'h01;
          on_ff <= duty_cnt_ff < pwm;
        end
      end
      assign blink_on[gb] = on_ff;
    end
  endgenerate

  // ****************************************
  // led drivers
  // ****************************************
  logic [15:0] led_drive; // pin pulled low when set

  // two selector bits per led, four leds per register
  genvar gl;
  generate
    for (gl = 0; gl < 16; gl++)
    begin : g_led
      wire [7:0] ls = cfg_ff[`LDR_IDX_SEL_G0 + 4'(gl / 4)];
      wire [1:0] sel = ls[2 * (gl % 4) +: 2];
      assign led_drive[gl] = (sel == `LDR_SEL_ON) ||
                             (sel == `LDR_SEL_BLINK_A && blink_on[0]) ||
                             (sel == `LDR_SEL_BLINK_B && blink_on[1]);
    end
  endgenerate

  // registered pin drive; off code leaves the pin released
  always_ff @(posedge clk)
  begin
    if (rst_int_ff)
    begin
      led_oe <= 16'h0000;
      led_o <= 16'h0000;
      blink_signal_a <= 1'b0;
      blink_signal_b <= 1'b0;
    end
    else
    begin
      led_oe <= led_drive;
      led_o <= 16'h0000;
      blink_signal_a <= blink_on[0];
      blink_signal_b <= blink_on[1];
    end
  end
endmodule

`default_nettype wire

// *** test/ldr_sva.sv ***
// ldr_sva: port-level timing checks of the led dimmer setup path
// assumes: bound to ldr_dimmer_top; one clock, sys_rst synchronous
`default_nettype none

module ldr_sva (
  // clock and reset sources
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ext_rst_n,
  input wire logic por_ok,
  // pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [15:0] led_o,
  input wire logic [15:0] led_oe,
  // visible state
  input wire logic auto_increment_flag,
  input wire ldr_pkg::ldr_ptr_t reg_ptr,
  input wire logic blink_signal_a,
  input wire logic blink_signal_b
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldr_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  // ****************************************
  // sequences
  // ****************************************
  // led enables, ack drive, flag and pointer at their reset levels
  sequence quiet;
    led_oe == 16'h0000 && !sda_oe && !auto_increment_flag && reg_ptr == 4'h0;
  endsequence
  // ack pull starts while scl is low
  sequence ack_rise;
    $rose(sda_oe) ##0 !scl_i;
  endsequence
  rst_quiet_a: assert property (sys_rst [*2] |=> quiet ##0 !blink_signal_a && !blink_signal_b)
    else $error("outputs not quiet under reset");
  ext_rst_a: assert property (!ext_rst_n [*4] |=> quiet)
    else $error("external reset not applied in time");
  por_hold_a: assert property (!por_ok [*4] |=> quiet)
    else $error("low supply did not hold reset");
  pins_low_a: assert property (disable iff (sys_rst) led_o == 16'h0000 && !sda_o)
    else $error("open-drain pin drives high");
  ack_hold_a: assert property (disable iff (sys_rst) ack_rise |-> sda_oe [*8])
    else $error("ack pull too short");
  ack_drop_a: assert property (disable iff (sys_rst) $fell(sda_oe) |-> !scl_i)
    else $error("ack released while scl high");
  ptr_wrap_a: assert property (disable iff (sys_rst)
    $past(reg_ptr) == 4'h9 && reg_ptr != 4'h9 && auto_increment_flag |-> reg_ptr == 4'h0)
    else $error("pointer did not wrap to zero");
  ptr_step_a: assert property (disable iff (sys_rst)
    auto_increment_flag && $past(auto_increment_flag) && $changed(reg_ptr)
    && $past(reg_ptr) inside {[4'h2:4'h8]} |-> reg_ptr == $past(reg_ptr) + 4'h1)
    else $error("pointer skipped a register");
endmodule

`default_nettype wire

// *** test/ldr_i2c_master.sv ***
// ldr_i2c_master: write-only i2c bus master model, msb first
// assumes: called at a falling clk edge; sda line has a pull-up
`default_nettype none

module ldr_i2c_master (
  // clock
  input wire logic clk,
  // bus lines
  input wire logic sda_line,
  output logic scl_o,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idles released
  initial
  begin
    scl_o = 1'b1;
    sda_drv = 1'b1;
  end
  // wait n falling edges
  task hp(input int n);
    repeat (n) @(negedge clk);
  endtask
  // sda falls while scl high
  task start;
    sda_drv = 1'b1;
    scl_o = 1'b1;
    hp(8);
    sda_drv = 1'b0;
    hp(8);
    scl_o = 0;
    hp(2);
  endtask
  // data changes only while scl is low
  task wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_drv = b[i];
      hp(8);
      scl_o = 1'b1;
      hp(8);
      scl_o = 1'b0;
      hp(2);
    end
    sda_drv = 1'b1;
    hp(8);
    scl_o = 1'b1;
    hp(4);
    ack = !sda_line;
    hp(4);
    scl_o = 1'b0;
    hp(2);
  endtask
  // sda rises while scl high
  task stop;
    sda_drv = 1'b0;
    hp(8);
    scl_o = 1'b1;
    hp(8);
    sda_drv = 1'b1;
    hp(8);
  endtask
endmodule

`default_nettype wire

// *** test/test_ldr_dimmer_top.sv ***
// test_ldr_dimmer_top: setup writes, blink timing, reset sources
// assumes: ldr_pkg, ldr_i2c_master and ldr_sva compiled first
`default_nettype none

module test_ldr_dimmer_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ldr_pkg::*;
  localparam int BD = 2; // shortened base divider
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_rst_n = 1'b1;
  logic por_ok = 1'b1;
  logic [2:0] pins = 3'h0;
  wire logic scl;
  wire logic sda_drv;
  logic sda_o, sda_oe, flag, ba, bb, ak;
  logic [15:0] led_o, led_oe;
  ldr_ptr_t ptr;
  // open-drain line with pull-up
  wire logic sda_w = sda_drv & (sda_o | !sda_oe);
  logic [31:0] exp_q[$];
  logic [31:0] got;
  logic [31:0] got_q[$]; // results waiting for the watcher
  event got_ev;
  int bad_count = 0;
  int checks_done = 0;
  int cnt;
  // command, eight registers, then one byte past the wrap into an input register
  logic [7:0] cfg[10] = '{8'h12, 8'h00, 8'h4d, 8'h4b, 8'h80, 8'h55, 8'haa, 8'hff, 8'h00, 8'h00};
  always #5 clk = ~clk;
  ldr_dimmer_top #(.BASE_DIV(BD)) ldr_dimmer_top_inst (.clk(clk), .sys_rst(sys_rst),
    .ext_rst_n(ext_rst_n), .por_ok(por_ok), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .address_select_inputs(pins), .led_o(led_o), .led_oe(led_oe),
    .auto_increment_flag(flag), .reg_ptr(ptr), .blink_signal_a(ba), .blink_signal_b(bb));
  ldr_i2c_master ldr_i2c_master_inst (.clk(clk), .sda_line(sda_w), .scl_o(scl),
    .sda_drv(sda_drv));
  // counts, verdict, end of run
  task end_of_test;
    // let the watcher take the last notes first
    #1;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // note the expectation, then hand the result to the watcher
  task note(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
    ->got_ev;
  endtask
  // watcher compares each result with the oldest note, draining all pending
  always @(got_ev)
  begin
    while (got_q.size() > 0)
    begin
      got = got_q.pop_front();
      checks_done++;
      if (got !== exp_q.pop_front())
      begin
        bad_count++;
        $display("[ERR] %0t mismatch, got %h", $time, got);
      end
    end
  end
  // one byte with its expected acknowledge
  task xfer(input logic [7:0] b, input logic a);
    ldr_i2c_master_inst.wbyte(b, ak);
    note(32'(a), 32'(ak));
  endtask
  // address, command, one data byte
  task wr1(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
    ldr_i2c_master_inst.start();
    xfer(a, 1'b1);
    xfer(c, 1'b1);
    xfer(d, 1'b1);
    ldr_i2c_master_inst.stop();
  endtask
  // bounded wait for a blink level, cycles counted in cnt
  task wt(input logic v, input logic b);
    cnt = 0;
    while ((b ? bb : ba) !== v)
    begin
      @(negedge clk);
      cnt++;
      if (cnt > 60000)
      begin
        bad_count++;
        $display("[ERR] %0t blink wait ran out", $time);
        end_of_test();
      end
    end
  endtask
  // on-time of a blink and the led group that follows it
  task blink(input logic b, input int g, input int hi);
    wt(1'b0, b);
    wt(1'b1, b);
    repeat (5) @(negedge clk);
    note(32'h0000_000f, 32'(led_oe[4*g +: 4]));
    wt(1'b0, b);
    note(32'(hi), 32'(cnt + 5));
    repeat (5) @(negedge clk);
    note(32'h0000_0000, 32'(led_oe[4*g +: 4]));
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'he4c9));
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    note(32'h0000_0000, 32'({led_oe, flag, ptr}));
    ldr_i2c_master_inst.start();
    xfer(8'hc0, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      xfer(cfg[i], 1'b1);
      note(32'((i + 2) % 10), 32'(ptr));
    end
    note(32'h0000_0001, 32'(flag));
    ldr_i2c_master_inst.stop();
    repeat (4) @(negedge clk);
    note(32'h0000_000f, 32'({led_oe[15:12], led_oe[3:0]}));
    blink(1'b0, 1, BD * 77);
    blink(1'b1, 2, BD * 76 * 128);
    pins = 3'($urandom_range(7, 1));
    wr1({4'hc, pins, 1'b0}, 8'h06, 8'h00);
    note(32'h0000_0006, 32'({flag, ptr}));
    note(32'h0000_0000, 32'(led_oe[3:0]));
    ldr_i2c_master_inst.start();
    xfer(8'hc0, 1'b0);
    ldr_i2c_master_inst.stop();
    pins = 3'h0;
    ldr_i2c_master_inst.start();
    xfer(8'hc1, 1'b0);
    ldr_i2c_master_inst.stop();
    for (int s = 0; s < 2; s++)
    begin
      wr1(8'hc0, 8'h06, 8'h55);
      note(32'h0000_000f, 32'(led_oe[3:0]));
      ext_rst_n = (s != 0);
      por_ok = (s == 0);
      repeat (10) @(negedge clk);
      note(32'h0000_0000, 32'({led_oe, ptr}));
      ext_rst_n = 1'b1;
      por_ok = 1'b1;
      repeat (8) @(negedge clk);
      note(32'h0000_0000, 32'({led_oe, flag, ptr}));
    end
    end_of_test();
  end
endmodule

bind ldr_dimmer_top ldr_sva ldr_sva_inst (.clk(clk), .sys_rst(sys_rst), .ext_rst_n(ext_rst_n),
  .por_ok(por_ok), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .led_o(led_o),
  .led_oe(led_oe), .auto_increment_flag(auto_increment_flag), .reg_ptr(reg_ptr),
  .blink_signal_a(blink_signal_a), .blink_signal_b(blink_signal_b));

`default_nettype wire
